// *** hw/dit_pkg.sv ***
/*
 * constants for the dual interval timer: register offsets, field positions,
 * reset values and the full count value.
 * assumes a byte-wide cpu bus with 8-bit addresses inside the special page.
 */
// Contract
// [RULE_01] flag sets when interval elapses; request only with both enables set
// [RULE_02] flag clears on interrupt service or by software write
// [RULE_03] flag is bit 7 of flag register two; other bits untouched
// [RULE_04] interval enable is bit 7 of enable register two
// [RULE_05] hold stops counter two; counter one only when cascade also set
// [RULE_06] control and counts keep contents at reset; flag and enable cleared
// [RULE_07] counter two clock: aux, sub-main, or aux/256 when cascaded
// [RULE_08] cascade makes one 16-bit counter, second stage at aux/256
// [RULE_09] counter one counts aux and gives lcd tick at aux/32..256
// [RULE_10] counter two drives the flag; counter writes act at once
// [RULE_11] interval select gives counter two clock divided by 2..256
package dit_pkg;
    localparam logic [7:0] ADDR_IRQ_FLAG_TWO = 8'h01;
    localparam logic [7:0] ADDR_IRQ_ENABLE_TWO = 8'h03;
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h40;
    localparam logic [7:0] ADDR_LCD_FRAME_COUNT = 8'h46;
    localparam logic [7:0] ADDR_INTERVAL_COUNT = 8'h47;

    localparam int BIT_INTERVAL_FLAG = 7;
    localparam int BIT_INTERVAL_IRQ_ENABLE = 7;
    localparam int BIT_SOURCE_SELECT = 7;
    localparam int BIT_COUNTER_HOLD = 6;
    localparam int BIT_CASCADE_SELECT = 5;
    localparam int POS_LCD_RATE = 3;
    localparam int POS_INTERVAL_SELECT = 0;
    // lcd tick from counter one bit 4 gives aux/32
    localparam int LCD_TICK_BASE_BIT = 4;

    localparam logic RST_INTERVAL_FLAG = 1'b0;
    localparam logic RST_INTERVAL_IRQ_ENABLE = 1'b0;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] COUNT_FULL = 8'hff;
endpackage : dit_pkg

// *** hw/dit_timer.sv ***
/*
 * dual interval timer: two cascadable 8-bit counters, interval flag and
 * lcd timing tick, registers on the cpu byte bus.
 * assumes aux and sub-main clocks are slow pins well below clk_i/2;
 * gie_i and irq_ack_i come from the cpu on clk_i.
 */
`timescale 1ns/1ps
module dit_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // cpu byte bus
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // cpu interrupt
    input wire logic gie_i,
    input wire logic irq_ack_i,
    output logic irq_o,
    // counter clock pins
    input wire logic aux_clk_i,
    input wire logic sub_main_clock_i,
    // lcd controller
    output logic lcd_timing_tick_o
);
    import dit_pkg::*;

    // ------------------------------------------------------------
    // clock pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [2:0] aux_sync_ff;
    logic [2:0] smc_sync_ff;
    // pins are asynchronous: two flops, then a third for the rising-edge detect
    always_ff @(posedge clk_i) begin
        aux_sync_ff <= {aux_sync_ff[1:0], aux_clk_i};
        smc_sync_ff <= {smc_sync_ff[1:0], sub_main_clock_i};
    end
    wire aux_edge = aux_sync_ff[1] & ~aux_sync_ff[2];
    wire smc_edge = smc_sync_ff[1] & ~smc_sync_ff[2];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // control and counts are deliberately left without reset
    logic [7:0] ctrl_ff;
    logic [7:0] cnt1_ff;
    logic [7:0] cnt2_ff;
    logic flag_ff;
    logic ie_ff;
    logic tick_ff;

    wire wr_flag = wr_i && addr_i == ADDR_IRQ_FLAG_TWO;
    wire wr_ie = wr_i && addr_i == ADDR_IRQ_ENABLE_TWO;
    wire wr_ctrl = wr_i && addr_i == ADDR_TIMER_CONTROL;
    wire wr_cnt1 = wr_i && addr_i == ADDR_LCD_FRAME_COUNT;
    wire wr_cnt2 = wr_i && addr_i == ADDR_INTERVAL_COUNT;

    wire source_select = ctrl_ff[BIT_SOURCE_SELECT];
    wire counter_hold = ctrl_ff[BIT_COUNTER_HOLD];
    wire cascade_select = ctrl_ff[BIT_CASCADE_SELECT];
    wire [1:0] lcd_rate_select = ctrl_ff[POS_LCD_RATE +: 2];
    wire [2:0] interval_select = ctrl_ff[POS_INTERVAL_SELECT +: 3];

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    // bit k falls on an increment when the low k+1 bits are all ones
    function automatic logic bit_falls(input logic [7:0] cnt, input logic [2:0] k);
        logic [7:0] mask;
        mask = 8'hff >> (3'd7 - k);
        bit_falls = (cnt & mask) == mask;
    endfunction : bit_falls

    wire cnt1_inc = aux_edge && !(counter_hold && cascade_select); // [RULE_05] [RULE_09]
    wire cnt1_wrap = cnt1_inc && cnt1_ff == COUNT_FULL;            // [RULE_08]
    // in cascade the wrap of counter one is the only clock of counter two
    wire cnt2_src = cascade_select ? cnt1_wrap :                   // [RULE_07] [RULE_08]
                    (source_select ? smc_edge : aux_edge);
    wire cnt2_inc = cnt2_src && !counter_hold;                     // [RULE_05]

    wire [2:0] lcd_bit = 3'(LCD_TICK_BASE_BIT) + {1'b0, lcd_rate_select};
    wire tick_set = cnt1_inc && bit_falls(cnt1_ff, lcd_bit);       // [RULE_09]
    wire flag_set = cnt2_inc && bit_falls(cnt2_ff, interval_select); // [RULE_10] [RULE_11]

    // writes beat increments so software values act at once
    wire [7:0] nxt_cnt1 = wr_cnt1 ? wdata_i : (cnt1_inc ? cnt1_ff + 8'h01 : cnt1_ff); // [RULE_10]
    wire [7:0] nxt_cnt2 = wr_cnt2 ? wdata_i : (cnt2_inc ? cnt2_ff + 8'h01 : cnt2_ff); // [RULE_10]

    always_ff @(posedge clk_i) begin // [RULE_06]
        cnt1_ff <= nxt_cnt1;
        cnt2_ff <= nxt_cnt2;
        if (wr_ctrl) begin
            ctrl_ff <= wdata_i;
        end
    end

    // ------------------------------------------------------------
    // interrupt flag, enable, tick and read data
    // ------------------------------------------------------------
    // set wins over service and software clear
    wire flag_clr = irq_ack_i || (wr_flag && !wdata_i[BIT_INTERVAL_FLAG]); // [RULE_02] [RULE_03]
    wire nxt_flag = flag_set || (wr_flag && wdata_i[BIT_INTERVAL_FLAG]) || (flag_ff && !flag_clr); // [RULE_01]

    // unmapped reads and bits owned by other modules return zero
    wire [7:0] rd_mux =
        (addr_i == ADDR_IRQ_FLAG_TWO) ? {flag_ff, 7'h00} :
        (addr_i == ADDR_IRQ_ENABLE_TWO) ? {ie_ff, 7'h00} :
        (addr_i == ADDR_TIMER_CONTROL) ? ctrl_ff :
        (addr_i == ADDR_LCD_FRAME_COUNT) ? cnt1_ff :
        (addr_i == ADDR_INTERVAL_COUNT) ? cnt2_ff : 8'h00;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            flag_ff <= RST_INTERVAL_FLAG;       // [RULE_06]
            ie_ff <= RST_INTERVAL_IRQ_ENABLE;   // [RULE_06]
            tick_ff <= 1'b0;
            rdata_o <= RST_READ_DATA;
        end else begin
            flag_ff <= nxt_flag;
            if (wr_ie) begin
                ie_ff <= wdata_i[BIT_INTERVAL_IRQ_ENABLE]; // [RULE_04]
            end
            tick_ff <= tick_set;
            if (rd_i) begin
                rdata_o <= rd_mux;
            end
        end
    end

    assign irq_o = flag_ff && ie_ff && gie_i; // [RULE_01]
    assign lcd_timing_tick_o = tick_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_IRQ_GATE: assert property (irq_o |-> flag_ff && ie_ff && gie_i) // [RULE_01]
        else $error("interrupt raised without flag and both enables");
    AST_ACK_CLEARS: assert property (irq_ack_i && !flag_set && !wr_flag |=> !flag_ff) // [RULE_02]
        else $error("flag not cleared by service");
    AST_SW_CLEAR: assert property (wr_flag && !wdata_i[7] && !flag_set |=> !flag_ff) // [RULE_03]
        else $error("flag not cleared by bit 7 write");
    AST_IE_WRITE: assert property (wr_ie |=> ie_ff == $past(wdata_i[7])) // [RULE_04]
        else $error("enable bit 7 not stored");
    AST_HOLD_CNT2: assert property (counter_hold && !wr_cnt2 |=> cnt2_ff == $past(cnt2_ff)) // [RULE_05]
        else $error("counter two moved while held");
    AST_RESET_CLEARS: assert property ($rose(rstn_i) |-> !flag_ff && !ie_ff) // [RULE_06]
        else $error("flag or enable not cleared by reset");
    AST_SMC_SOURCE: assert property (source_select && !cascade_select && !counter_hold && smc_edge && !wr_cnt2
        |=> cnt2_ff == $past(cnt2_ff) + 8'h01) // [RULE_07]
        else $error("counter two missed sub-main edge");
    AST_CASCADE: assert property (cascade_select && !counter_hold && aux_edge && cnt1_ff == 8'hff
        && !wr_cnt1 && !wr_cnt2 |=> cnt1_ff == 8'h00 && cnt2_ff == $past(cnt2_ff) + 8'h01) // [RULE_08]
        else $error("cascade carry lost");
    AST_CNT1_AUX: assert property (aux_edge && !(counter_hold && cascade_select) && !wr_cnt1
        |=> cnt1_ff == $past(cnt1_ff) + 8'h01) // [RULE_09]
        else $error("counter one missed aux edge");
    AST_CNT_WRITE: assert property (wr_cnt1 |=> cnt1_ff == $past(wdata_i)) // [RULE_10]
        else $error("counter one write not immediate");
    AST_DIV2_FLAG: assert property (cnt2_inc && interval_select == 3'h0 && cnt2_ff[0] && !wr_cnt2
        |=> flag_ff) // [RULE_11]
        else $error("flag not set at divide-by-two interval");

    // ------------------------------------------------------------
    // interrupt checks
    // ------------------------------------------------------------
    // set wins over clears, so AST_ACK_CLEARS and AST_SW_CLEAR excuse a same-cycle set
    AST_IRQ_FOLLOWS: assert property (flag_set && ie_ff && !wr_ie |=> irq_o == gie_i) // [RULE_01]
        else $error("interrupt request does not follow new flag");
    AST_FLAG_STAYS: assert property (flag_ff && !irq_ack_i && !wr_flag |=> flag_ff) // [RULE_02]
        else $error("flag dropped without service or clear");
    AST_SW_SET: assert property (wr_flag && wdata_i[7] |=> flag_ff) // [RULE_03]
        else $error("flag not set by bit 7 write");
    AST_IE_STAYS: assert property (!wr_ie |=> $stable(ie_ff)) // [RULE_04]
        else $error("enable changed without a write");
    AST_FLAG_QUIET: assert property (!flag_ff && !flag_set && !(wr_flag && wdata_i[7]) // [RULE_10]
        |=> !flag_ff)
        else $error("flag set without counter two interval");

    // ------------------------------------------------------------
    // counter checks
    // ------------------------------------------------------------
    // pins run slower than clk_i/4, so detected edges are never adjacent
    AST_HOLD_CNT1: assert property (counter_hold && cascade_select && !wr_cnt1 |=> $stable(cnt1_ff)) // [RULE_05]
        else $error("counter one moved while held in cascade");
    AST_AUX_SOURCE: assert property (!source_select && !cascade_select && !counter_hold && aux_edge // [RULE_07]
        && !wr_cnt2 |=> cnt2_ff == $past(cnt2_ff) + 8'h01)
        else $error("counter two missed aux edge");
    AST_NO_CARRY: assert property (cascade_select && aux_edge && cnt1_ff != COUNT_FULL && !wr_cnt2 // [RULE_08]
        |=> $stable(cnt2_ff))
        else $error("counter two moved without carry");
    AST_TICK_RATE: assert property (cnt1_inc && lcd_rate_select == 2'h0 && cnt1_ff[4:0] == 5'h1f // [RULE_09]
        |=> lcd_timing_tick_o)
        else $error("lcd tick missing at divide-by-32");
    AST_TICK_ONE: assert property (lcd_timing_tick_o |=> !lcd_timing_tick_o) // [RULE_09]
        else $error("lcd tick longer than one cycle");
    AST_EARLY_QUIET: assert property (cnt2_inc && interval_select == 3'h7 && cnt2_ff != COUNT_FULL // [RULE_11]
        && !flag_ff && !wr_flag |=> !flag_ff)
        else $error("flag set before divide-by-256 interval");

    // ------------------------------------------------------------
    // bus checks
    // ------------------------------------------------------------
    AST_CNT2_WRITE: assert property (wr_cnt2 |=> cnt2_ff == $past(wdata_i)) // [RULE_10]
        else $error("counter two write not immediate");
    AST_RD_HOLD: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data changed without a read");

    // ------------------------------------------------------------
    // cover properties
    // ------------------------------------------------------------
    // main scenarios: interrupt, cascade carry, lcd tick, set against service, sub-main count
    COV_IRQ: cover property (flag_set && ie_ff && gie_i ##1 irq_o);
    COV_CASCADE_WRAP: cover property (cascade_select && cnt1_wrap);
    COV_LCD_TICK: cover property (lcd_timing_tick_o);
    COV_SET_VS_ACK: cover property (flag_set && irq_ack_i);
    COV_SMC_COUNT: cover property (source_select && !cascade_select && smc_edge);
endmodule : dit_timer

// *** tb/dit_partner.sv ***
/*
 * far side model: drives the aux and sub-main clock pins.
 * assumes clk_i is the bench clock; pins stand low outside bursts.
 */
`timescale 1ns/1ps
module dit_partner (
    // bench clock
    input wire logic clk_i,
    // counter clock pins
    output logic aux_clk_o,
    output logic sub_main_clock_o
);
    initial begin
        aux_clk_o = 1'b0;
        sub_main_clock_o = 1'b0;
    end
    // aux burst, 8 clk_i per period, well below clk_i/4
    task automatic pulse_aux(input int n);
        repeat (n) begin
            aux_clk_o = 1'b1;
            repeat (4) @(posedge clk_i);
            #1 aux_clk_o = 1'b0;
            repeat (4) @(posedge clk_i);
            #1;
        end
    endtask : pulse_aux
    // sub-main burst, same shape as the aux burst
    task automatic pulse_smc(input int n);
        repeat (n) begin
            sub_main_clock_o = 1'b1;
            repeat (4) @(posedge clk_i);
            #1 sub_main_clock_o = 1'b0;
            repeat (4) @(posedge clk_i);
            #1;
        end
    endtask : pulse_smc
endmodule : dit_partner

// *** tb/test_dit_timer.sv ***
/*
 * testbench for dit_timer: byte bus tasks, counting bursts, interrupt.
 * assumes dit_partner drives the clock pins.
 */
`timescale 1ns/1ps
module test_dit_timer;
    import dit_pkg::*;
    logic clk_i, rstn_i, wr_i, rd_i, gie_i, irq_ack_i, irq_o, aux_clk_i, sub_main_clock_i, tick;
    logic [7:0] addr_i, wdata_i, rdata_o;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_tick = 0;
    int tick_base = 0;
    dit_timer u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .gie_i(gie_i), .irq_ack_i(irq_ack_i), .irq_o(irq_o),
        .aux_clk_i(aux_clk_i), .sub_main_clock_i(sub_main_clock_i), .lcd_timing_tick_o(tick));
    dit_partner u_far (.clk_i(clk_i), .aux_clk_o(aux_clk_i), .sub_main_clock_o(sub_main_clock_i));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (tick === 1'b1) n_tick++;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(posedge clk_i);
        #1 wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_i);
        #1;
        addr_i = a;
        rd_i = 1'b1;
        @(posedge clk_i);
        #1 rd_i = 1'b0;
        chk(what, exp, rdata_o);
    endtask : rd
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {rstn_i, wr_i, rd_i, gie_i, irq_ack_i, addr_i, wdata_i} = '0;
        repeat (12) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        rd(8'h01, 8'h00, "flag reg");
        rd(8'h03, 8'h00, "enable reg");
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h80, "enable reg");
        wr(8'h01, 8'h7f);
        rd(8'h01, 8'h00, "flag reg");
        rd(8'h10, 8'h00, "unmapped");
        wr(8'h47, 8'h5a);
        rd(8'h47, 8'h5a, "count two");
        wr(8'h46, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(8'h40, 8'(k));
            wr(8'h47, 8'h00);
            wr(8'h01, 8'h00);
            u_far.pulse_aux((2 << k) - 1);
            rd(8'h01, 8'h00, "flag early");
            u_far.pulse_aux(1);
            rd(8'h01, 8'h80, "flag due");
        end
        chk("irq gie off", 8'h00, {7'h0, irq_o});
        gie_i = 1'b1;
        @(posedge clk_i);
        #1 chk("irq on", 8'h01, {7'h0, irq_o});
        irq_ack_i = 1'b1;
        @(posedge clk_i);
        #1 irq_ack_i = 1'b0;
        rd(8'h01, 8'h00, "flag serviced");
        wr(8'h01, 8'h80);
        rd(8'h01, 8'h80, "flag software set");
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h00, "flag software");
        wr(8'h40, 8'h40);
        wr(8'h46, 8'h00);
        wr(8'h47, 8'h05);
        u_far.pulse_aux(3);
        rd(8'h47, 8'h05, "held count two");
        rd(8'h46, 8'h03, "count one");
        wr(8'h40, 8'h20);
        wr(8'h46, 8'hff);
        wr(8'h47, 8'h00);
        u_far.pulse_aux(1);
        rd(8'h46, 8'h00, "cascade one");
        rd(8'h47, 8'h01, "cascade two");
        wr(8'h40, 8'h60);
        u_far.pulse_aux(2);
        rd(8'h46, 8'h00, "held count one");
        rd(8'h47, 8'h01, "held cascade two");
        wr(8'h40, 8'h80);
        wr(8'h47, 8'h00);
        u_far.pulse_aux(2);
        rd(8'h47, 8'h00, "sub-main source");
        u_far.pulse_smc(3);
        rd(8'h47, 8'h03, "sub-main count");
        wr(8'h01, 8'h80);
        @(posedge clk_i);
        #1 rstn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        rd(8'h01, 8'h00, "flag after reset");
        rd(8'h03, 8'h00, "enable after reset");
        rd(8'h40, 8'h80, "control kept");
        rd(8'h47, 8'h03, "count two kept");
        chk("irq after reset", 8'h00, {7'h0, irq_o});
        for (int r = 0; r < 4; r++) begin
            wr(8'h40, 8'h40 | 8'(r << 3));
            wr(8'h46, 8'h00);
            tick_base = n_tick;
            u_far.pulse_aux(256);
            chk("lcd ticks", 8'h08 >> r, 8'(n_tick - tick_base));
        end
        tally_and_finish();
    end
endmodule : test_dit_timer
